/* bpa_port.v */
// Summary of operation
// R1 - Eight pins, each configured independently
// R2 - Reset: inputs, select ones, latch zero
// R3 - Output pins driven from latch
// R4 - Digital input reads live pin level
// R5 - Analog pin disables input, reads zero
// R6 - Output pins read back latch content
// R7 - Digital inputs feed interrupt and wakeup
// R8 - Read-modify-write captures input pin levels
// R9 - Software: analog pins never set output
// R10 - Software: avoid output activity during conversion
// R11 - Data writes update every latch in any pin mode; a write while clk_en is low is dropped
`timescale 1ns/100ps
`default_nettype none
`include "bpa_regs.vh"
module bpa_port (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	input wire clk_en,
	// Register port
	input wire [11:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [7:0] reg_rdata_ff,
	// Pins
	input wire [7:0] pin_in,
	output wire [7:0] pin_out,
	output wire [7:0] pin_oe,
	// Analog converter side
	output wire [7:0] analog_enable,
	// Interrupt and key-on wakeup side
	output wire [7:0] wake_level,
	output wire [7:0] wake_valid
);
	// ----------------------------------------
	// Select codes
	// ----------------------------------------
	// One-hot register select; all zero means the address is not mapped.
	// Unmapped writes are dropped and unmapped reads return zero.
	localparam [2:0] SEL_NONE = 3'h0;
	localparam [2:0] SEL_DATA = 3'h1;
	localparam [2:0] SEL_DIR = 3'h2;
	localparam [2:0] SEL_INSEL = 3'h4;

	// ----------------------------------------
	// Register state and next values
	// ----------------------------------------
	reg [7:0] port_data_latch_ff;
	reg [7:0] port_direction_ff;
	reg [7:0] port_input_select_ff;
	reg [7:0] nxt_data_latch;
	reg [7:0] nxt_direction;
	reg [7:0] nxt_input_select;
	reg [7:0] nxt_rdata;
	wire [7:0] pin_sync;
	wire [7:0] data_view;
	wire [2:0] addr_sel;

	// ----------------------------------------
	// Decode functions
	// ----------------------------------------
	// Address decode, shared by the write and the read path
	function [2:0] reg_select;
		input [`BPA_ADDR_W-1:0] addr;
		begin
			if (addr == `BPA_OFS_DATA) begin
				reg_select = SEL_DATA;
			end else if (addr == `BPA_OFS_DIR) begin
				reg_select = SEL_DIR;
			end else if (addr == `BPA_OFS_INSEL) begin
				reg_select = SEL_INSEL;
			end else begin
				reg_select = SEL_NONE;
			end
		end
	endfunction

	// Pin is an analog input: not driven and digital input path off
	function is_analog;
		input dir;
		input sel;
		begin
			is_analog = ~dir & ~sel;
		end
	endfunction

	// Pin is a digital input: also the source for interrupt and wakeup
	function is_digital_in;
		input dir;
		input sel;
		begin
			is_digital_in = ~dir & sel;
		end
	endfunction

	// Read-back value of one data bit in its current mode
	function bit_view;
		input dir;
		input sel;
		input latch;
		input pin;
		begin
			if (dir) begin
				bit_view = latch;
			end else if (is_digital_in(dir, sel)) begin
				bit_view = pin;
			end else begin
				bit_view = `BPA_PIN_LO;
			end
		end
	endfunction

	// ----------------------------------------
	// Per-pin logic
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < `BPA_WIDTH; g = g + 1) begin : g_pin
			// Pins change with no regard to core_clk, so each one is filtered
			bpa_sync3 u_sync (
				.core_clk(core_clk),
				.rst_n(rst_n),
				.clk_en(clk_en),
				.pin_in(pin_in[g]),
				.pin_clean_ff(pin_sync[g])
			); // [R1]
			// Each pin follows only its own control bits
			assign pin_out[g] = port_data_latch_ff[g]; // [R3]
			assign pin_oe[g] = port_direction_ff[g]; // [R3]
			assign analog_enable[g] = is_analog(port_direction_ff[g],
				port_input_select_ff[g]); // [R5]
			assign wake_valid[g] = is_digital_in(port_direction_ff[g],
				port_input_select_ff[g]); // [R7]
			// Gated so that driven and analog pins never disturb the wakeup logic
			assign wake_level[g] = pin_sync[g] & wake_valid[g]; // [R7]
			// The same view serves plain reads and read-modify-write, so digital input
			// bits hand their pin level back to the latch when software rewrites it
			assign data_view[g] = bit_view(port_direction_ff[g], port_input_select_ff[g],
				port_data_latch_ff[g], pin_sync[g]); // [R4] [R5] [R6] [R8]
		end
	endgenerate

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	assign addr_sel = reg_select(reg_addr);

	always @* begin
		nxt_data_latch = port_data_latch_ff;
		nxt_direction = port_direction_ff;
		nxt_input_select = port_input_select_ff;
		if (reg_wr) begin
			if (addr_sel == SEL_DATA) begin
				// Stored whatever the mode, ready for when the pin turns output
				nxt_data_latch = reg_wdata; // [R11]
			end else if (addr_sel == SEL_DIR) begin
				nxt_direction = reg_wdata; // [R1]
			end else if (addr_sel == SEL_INSEL) begin
				nxt_input_select = reg_wdata; // [R1]
			end
		end
	end

	// ----------------------------------------
	// Register reads
	// ----------------------------------------
	// Reads have no side effects; idle enabled cycles and unmapped addresses give zero
	always @* begin
		nxt_rdata = `BPA_RD_NONE;
		if (reg_rd) begin
			if (addr_sel == SEL_DATA) begin
				nxt_rdata = data_view; // [R4] [R6]
			end else if (addr_sel == SEL_DIR) begin
				nxt_rdata = port_direction_ff;
			end else if (addr_sel == SEL_INSEL) begin
				nxt_rdata = port_input_select_ff;
			end
		end
	end

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// clk_en low freezes every register, read data included
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_data_latch_ff <= `BPA_RST_DATA; // [R2]
		end else if (clk_en) begin
			port_data_latch_ff <= nxt_data_latch;
		end
	end

	// Direction resets to input so that no pin is driven before software asks
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_direction_ff <= `BPA_RST_DIR; // [R2]
		end else if (clk_en) begin
			port_direction_ff <= nxt_direction;
		end
	end

	// Select resets to digital input, the safe state for an undriven pin
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			port_input_select_ff <= `BPA_RST_INSEL; // [R2]
		end else if (clk_en) begin
			port_input_select_ff <= nxt_input_select;
		end
	end

	// Read data stand for one enabled cycle only and then fall back to zero,
	// so a stale value can never be mistaken for a fresh read
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_ff <= `BPA_RD_NONE;
		end else if (clk_en) begin
			reg_rdata_ff <= nxt_rdata;
		end
	end
endmodule
`default_nettype wire

/* bpa_regs.vh */
`ifndef BPA_REGS_VH
`define BPA_REGS_VH
// ----------------------------------------
// Register map
// ----------------------------------------
`define BPA_ADDR_W 12
`define BPA_WIDTH 8
`define BPA_OFS_DATA 12'h007
`define BPA_OFS_DIR 12'hf9d
`define BPA_OFS_INSEL 12'hf9e
// ----------------------------------------
// Reset values
// ----------------------------------------
`define BPA_RST_DATA 8'h00
`define BPA_RST_DIR 8'h00
`define BPA_RST_INSEL 8'hff
`define BPA_RD_NONE 8'h00
`define BPA_PIN_LO 1'b0
`endif

/* bpa_sync3.v */
`timescale 1ns/100ps
`default_nettype none
`include "bpa_regs.vh"
module bpa_sync3 (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	input wire clk_en,
	// Pin level
	input wire pin_in,
	output reg pin_clean_ff
);
	reg meta_ff;
	reg s2_ff;
	reg s3_ff;
	// Change accepted only once the second and third stages agree
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= `BPA_PIN_LO;
			s2_ff <= `BPA_PIN_LO;
			s3_ff <= `BPA_PIN_LO;
			pin_clean_ff <= `BPA_PIN_LO;
		end else if (clk_en) begin
			meta_ff <= pin_in;
			s2_ff <= meta_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				pin_clean_ff <= s3_ff;
			end
		end
	end
endmodule
`default_nettype wire

/* bpa_chk.sv */
`timescale 1ns/100ps
`default_nettype none
module bpa_chk (
	// Clock and control
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// Register port
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_ff,
	// Pins
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	// Converter and wakeup side
	input wire logic [7:0] analog_enable,
	input wire logic [7:0] wake_level,
	input wire logic [7:0] wake_valid
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	wire rd7 = reg_rd & clk_en & reg_addr == 12'h007;
	wire wr7 = reg_wr & clk_en & reg_addr == 12'h007;
	wire wrd = reg_wr & clk_en & reg_addr == 12'hf9d;
	dir_write_a: assert property (wrd |=> pin_oe == $past(reg_wdata))
		else $error("direction write lost");
	latch_write_a: assert property (wr7 |=> pin_out == $past(reg_wdata))
		else $error("latch write lost");
	// Every undriven pin is exactly one of analog or digital input
	mode_split_a: assert property ((analog_enable ^ wake_valid) == ~pin_oe)
		else $error("pin mode split wrong");
	wake_gate_a: assert property ((wake_level & ~wake_valid) == 0)
		else $error("wake level leaks");
	rd_out_a: assert property (rd7 |=> (reg_rdata_ff & $past(pin_oe)) ==
		($past(pin_out) & $past(pin_oe)))
		else $error("output bits not latch");
	rd_ana_a: assert property (rd7 |=> (reg_rdata_ff & $past(analog_enable)) == 0)
		else $error("analog bit not zero");
	rd_pin_a: assert property (rd7 |=> (reg_rdata_ff & $past(wake_valid)) == $past(wake_level))
		else $error("input bits not pin");
	rd_idle_a: assert property (clk_en && !reg_rd |=> reg_rdata_ff == 0)
		else $error("read data lingers");
	freeze_hold_a: assert property (!clk_en |=> $stable(pin_out)
		&& $stable(pin_oe) && $stable(reg_rdata_ff))
		else $error("state moved while frozen");
endmodule
bind bpa_port bpa_chk bpa_chk_i (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata_ff(reg_rdata_ff), .pin_out(pin_out), .pin_oe(pin_oe),
	.analog_enable(analog_enable), .wake_level(wake_level), .wake_valid(wake_valid));
`default_nettype wire

/* bpa_pins.sv */
`timescale 1ns/100ps
`default_nettype none
// Driven pins show the latch, the rest the outside level; no analog pin is driven
module bpa_pins (input wire logic [7:0] pin_out, pin_oe, ext_lvl, output logic [7:0] pin_in);
	assign pin_in = (pin_out & pin_oe) | (ext_lvl & ~pin_oe);
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic core_clk = 0, rst_n = 0, clk_en = 1, reg_wr = 0, reg_rd = 0;
	logic [11:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, ext_lvl = 0, reg_rdata_ff, pin_in, pin_out, pin_oe;
	logic [7:0] analog_enable, wake_level, wake_valid;
	int n_fail = 0, checks_done = 0;
	always #10 core_clk = ~core_clk;
	bpa_port bpa_port_i (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_ff(reg_rdata_ff), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.analog_enable(analog_enable), .wake_level(wake_level), .wake_valid(wake_valid));
	bpa_pins bpa_pins_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));
	task chk(input logic [7:0] s, e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("FAIL %0t got %h want %h", $time, s, e);
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1;
		@(posedge core_clk);
		reg_rd <= 0;
		#1 chk(reg_rdata_ff, e);
	endtask
	task t_reset;
		rd(12'h007, 8'h00);
		rd(12'hf9d, 8'h00);
		rd(12'hf9e, 8'hff);
		$display("reset test done");
	endtask
	task t_modes;
		ext_lvl <= 8'hff;
		wr(12'h007, 8'ha5);
		wr(12'hf9d, 8'h0f);
		wr(12'hf9e, 8'h3c);
		repeat (6) @(posedge core_clk);
		rd(12'h007, 8'h35);
		chk(pin_out, 8'ha5);
		chk(pin_oe, 8'h0f);
		chk(analog_enable, 8'hc0);
		chk(wake_valid, 8'h30);
		chk(wake_level, 8'h30);
		ext_lvl <= 8'h00;
		repeat (6) @(posedge core_clk);
		rd(12'h007, 8'h05);
		chk(wake_level, 8'h00);
		rd(12'h100, 8'h00);
		$display("mode test done");
	endtask
	task t_rmw;
		ext_lvl <= 8'hff;
		wr(12'h007, 8'h05);
		repeat (6) @(posedge core_clk);
		rd(12'h007, 8'h35);
		wr(12'h007, reg_rdata_ff ^ 8'h01);
		wr(12'hf9d, 8'hff);
		rd(12'h007, 8'h34);
		@(posedge core_clk);
		clk_en <= 0;
		wr(12'h007, 8'h00);
		clk_en <= 1;
		rd(12'h007, 8'h34);
		$display("rmw test done");
	endtask
	task t_rerst;
		@(posedge core_clk);
		rst_n <= 0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1;
		chk(pin_oe, 8'h00);
		chk(pin_out, 8'h00);
		t_reset;
	endtask
	task tally_and_finish;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1;
		t_reset;
		t_modes;
		t_rmw;
		t_rerst;
		tally_and_finish;
	end
	// Tests take well under a thousand cycles
	initial begin
		#100000;
		n_fail++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
